// ### logic/dpc_edge_launch.sv
`timescale 1ns/100ps
module dpc_edge_launch (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Output clock and data
	input wire logic out_clk,
	input wire logic rise_sel,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out
);
	import dpc_pkg::*;
	logic out_clk_r;
	logic launch;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_clk_r <= 1'b0;
		end else begin
			out_clk_r <= out_clk;
		end
	end

	assign launch = rise_sel ? (out_clk & ~out_clk_r) : (~out_clk & out_clk_r);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_out <= 8'h00;
		end else if (launch) begin
			data_out <= data_in;
		end
	end
endmodule

// ### logic/dpc_luma_delay.sv
`timescale 1ns/100ps
module dpc_luma_delay (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Samples
	input wire logic [7:0] luma_in,
	input wire logic [7:0] chroma_in,
	input wire logic signed [3:0] delay,
	output logic [7:0] luma_out,
	output logic [7:0] chroma_out
);
	import dpc_pkg::*;
	logic [7:0] luma_line_r [DPC_DELAY_TAPS+1];
	logic [7:0] chroma_line_r [DPC_DELAY_TAPS+1];
	logic [3:0] luma_sel;
	logic [3:0] chroma_sel;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i <= DPC_DELAY_TAPS; i++) begin
				luma_line_r[i] <= 8'h00;
				chroma_line_r[i] <= 8'h00;
			end
		end else begin
			luma_line_r[0] <= luma_in;
			chroma_line_r[0] <= chroma_in;
			for (int i = 1; i <= DPC_DELAY_TAPS; i++) begin
				luma_line_r[i] <= luma_line_r[i-1];
				chroma_line_r[i] <= chroma_line_r[i-1];
			end
		end
	end

	// Negative codes advance luma: chroma waits low bits plus one
	always_comb begin
		if (delay[3]) begin
			luma_sel = 4'h0;
			chroma_sel = {1'b0, delay[2:0]} + 4'h1;
		end else begin
			luma_sel = 4'(delay);
			chroma_sel = 4'h0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			luma_out <= 8'h00;
			chroma_out <= 8'h00;
		end else begin
			luma_out <= luma_line_r[luma_sel];
			chroma_out <= chroma_line_r[chroma_sel];
		end
	end
endmodule

// ### logic/dpc_picture_regs.sv
`timescale 1ns/100ps
module dpc_picture_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Autoswitch
	input wire logic [3:0] std_detect_req,
	input wire logic std_detect_valid,
	input wire logic std_is_secam,
	output dpc_pkg::dpc_mask_t autoswitch_mask,
	output logic std_accept,
	// Output clocks
	input wire logic main_clk,
	input wire logic sec_clk,
	output logic sec_clk_o,
	output logic sec_clk_oe,
	// Video in
	input wire logic vertical_blanking_interval,
	input wire logic vertical_active_interval,
	input wire logic [7:0] luma_in,
	input wire logic [7:0] luma2x_in,
	input wire logic [7:0] chroma_in,
	input wire logic [4:0] burst_level,
	input wire logic raw_header_slot,
	// Video out
	output logic [7:0] main_data,
	output logic [7:0] sec_data,
	output logic [1:0] out_mode,
	output logic color_killed,
	output logic pedestal_absent,
	output logic trap_filter_sel,
	output logic [1:0] peaking_gain,
	output dpc_pkg::dpc_picture_t picture,
	output logic hue_enable
);
	import dpc_pkg::*;

	logic [7:0] mask_r;
	logic [7:0] clk_r;
	logic [7:0] kill_r;
	logic [7:0] luma1_r;
	logic [7:0] luma2_r;
	logic [7:0] bright_r;
	logic [7:0] sat_r;
	logic [7:0] hue_r;
	logic [7:0] contrast_r;
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	dpc_kill_t kill_mode;
	dpc_omode_t out_mode_nxt;
	logic killed_nxt;
	logic [7:0] dly_luma;
	logic [7:0] dly_chroma;
	logic [7:0] stream_nxt;
	logic [7:0] stream_r;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_ix);
		addr_is = (a == reg_ix);
	endfunction

	// Register writes
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_r <= DPC_RST_MASK;
			clk_r <= DPC_RST_CLK;
			kill_r <= DPC_RST_KILL;
			luma1_r <= DPC_RST_LUMA1;
			luma2_r <= DPC_RST_LUMA2;
			bright_r <= DPC_RST_BRIGHT;
			sat_r <= DPC_RST_SAT;
			hue_r <= DPC_RST_HUE;
			contrast_r <= DPC_RST_CONTRAST;
		end else if (reg_wr) begin
			if (addr_is(reg_addr, DPC_ADDR_MASK))
				mask_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_CLK))
				clk_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_KILL))
				kill_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_LUMA1))
				luma1_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_LUMA2))
				luma2_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_BRIGHT))
				bright_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_SAT))
				sat_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_HUE))
				hue_r <= reg_wdata;
			if (addr_is(reg_addr, DPC_ADDR_CONTRAST))
				contrast_r <= reg_wdata;
		end
	end

	// Read mux
	always_comb begin
		rdata_nxt = 8'h00;
		hit_nxt = 1'b1;
		case (reg_addr)
			DPC_ADDR_MASK: rdata_nxt = mask_r;
			DPC_ADDR_CLK: rdata_nxt = clk_r;
			DPC_ADDR_KILL: rdata_nxt = kill_r;
			DPC_ADDR_LUMA1: rdata_nxt = luma1_r;
			DPC_ADDR_LUMA2: rdata_nxt = luma2_r;
			DPC_ADDR_BRIGHT: rdata_nxt = bright_r;
			DPC_ADDR_SAT: rdata_nxt = sat_r;
			DPC_ADDR_HUE: rdata_nxt = hue_r;
			DPC_ADDR_CONTRAST: rdata_nxt = contrast_r;
			default: hit_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
			reg_hit <= hit_nxt;
		end
	end

	// Autoswitch masking
	assign autoswitch_mask.ntsc443_autoswitch_mask = mask_r[DPC_BIT_N443];
	assign autoswitch_mask.paln_autoswitch_mask = mask_r[DPC_BIT_PALN];
	assign autoswitch_mask.palm_autoswitch_mask = mask_r[DPC_BIT_PALM];
	assign autoswitch_mask.secam_autoswitch_mask = mask_r[DPC_BIT_SECAM];
	// Request one-hot: 3 NTSC443, 2 PAL-N, 1 PAL-M, 0 SECAM
	assign std_accept = std_detect_valid & ~|(std_detect_req & autoswitch_mask);

	// Secondary clock pin
	assign sec_clk_o = sec_clk;
	assign sec_clk_oe = clk_r[DPC_BIT_SCLK_OE];

	// Color killer
	assign kill_mode = dpc_kill_t'(kill_r[DPC_POS_KILL_MODE +: 2]);
	always_comb begin
		case (kill_mode)
			DPC_KILL_AUTO: killed_nxt = burst_level > kill_r[4:0];
			DPC_KILL_FORCE: killed_nxt = 1'b1;
			DPC_KILL_OFF: killed_nxt = 1'b0;
			default: killed_nxt = 1'b0;
		endcase
	end

	// Output mode selection
	always_comb begin
		if (luma1_r[DPC_BIT_LUMA2X])
			out_mode_nxt = DPC_OUT_LUMA2X;
		else if (luma1_r[DPC_BIT_BYPASS] && vertical_blanking_interval
			&& !vertical_active_interval)
			out_mode_nxt = DPC_OUT_LUMA2X;
		else
			out_mode_nxt = DPC_OUT_YCBCR;
	end

	dpc_luma_delay u_delay (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.luma_in(luma_in),
		.chroma_in(killed_nxt ? 8'h00 : chroma_in),
		.delay(signed'(luma1_r[3:0])),
		.luma_out(dly_luma),
		.chroma_out(dly_chroma)
	);

	// Stream assembly
	always_comb begin
		if (raw_header_slot && luma1_r[DPC_BIT_RAWHDR])
			stream_nxt = DPC_DUMMY_HDR;
		else if (out_mode_nxt == DPC_OUT_LUMA2X)
			stream_nxt = luma2x_in;
		else
			stream_nxt = main_clk ? dly_luma : dly_chroma;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stream_r <= 8'h00;
			out_mode <= DPC_OUT_YCBCR;
			color_killed <= 1'b0;
		end else begin
			stream_r <= stream_nxt;
			out_mode <= out_mode_nxt;
			color_killed <= killed_nxt;
		end
	end

	dpc_edge_launch u_main (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.out_clk(main_clk),
		.rise_sel(clk_r[DPC_BIT_CLK_EDGE]),
		.data_in(stream_r),
		.data_out(main_data)
	);

	dpc_edge_launch u_sec (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.out_clk(sec_clk),
		.rise_sel(clk_r[DPC_BIT_SCLK_EDGE]),
		.data_in(stream_r),
		.data_out(sec_data)
	);

	// Luma and picture controls, live
	assign pedestal_absent = luma1_r[DPC_BIT_PED];
	assign trap_filter_sel = luma2_r[DPC_BIT_TRAP];
	assign peaking_gain = luma2_r[DPC_POS_PEAK +: 2];
	assign picture.brightness = bright_r;
	assign picture.saturation = sat_r;
	assign picture.hue = signed'(hue_r);
	assign picture.contrast = contrast_r;
	assign hue_enable = ~std_is_secam;
endmodule

// ### logic/dpc_pkg.sv
package dpc_pkg;
	// Register indices (byte subaddresses on the control port)
	localparam logic [7:0] DPC_ADDR_MASK = 8'h04;
	localparam logic [7:0] DPC_ADDR_CLK = 8'h05;
	localparam logic [7:0] DPC_ADDR_KILL = 8'h06;
	localparam logic [7:0] DPC_ADDR_LUMA1 = 8'h07;
	localparam logic [7:0] DPC_ADDR_LUMA2 = 8'h08;
	localparam logic [7:0] DPC_ADDR_BRIGHT = 8'h09;
	localparam logic [7:0] DPC_ADDR_SAT = 8'h0A;
	localparam logic [7:0] DPC_ADDR_HUE = 8'h0B;
	localparam logic [7:0] DPC_ADDR_CONTRAST = 8'h0C;
	// Reset values
	localparam logic [7:0] DPC_RST_MASK = 8'hDC;
	localparam logic [7:0] DPC_RST_CLK = 8'h08;
	localparam logic [7:0] DPC_RST_KILL = 8'h10;
	localparam logic [7:0] DPC_RST_LUMA1 = 8'h60;
	localparam logic [7:0] DPC_RST_LUMA2 = 8'h00;
	localparam logic [7:0] DPC_RST_BRIGHT = 8'h80;
	localparam logic [7:0] DPC_RST_SAT = 8'h80;
	localparam logic [7:0] DPC_RST_HUE = 8'h00;
	localparam logic [7:0] DPC_RST_CONTRAST = 8'h80;
	// Field positions
	localparam int DPC_BIT_N443 = 7;
	localparam int DPC_BIT_PALN = 6;
	localparam int DPC_BIT_PALM = 4;
	localparam int DPC_BIT_SECAM = 5;
	localparam int DPC_BIT_CLK_EDGE = 0;
	localparam int DPC_BIT_SCLK_EDGE = 1;
	localparam int DPC_BIT_SCLK_OE = 3;
	localparam int DPC_POS_KILL_MODE = 5;
	localparam int DPC_BIT_LUMA2X = 7;
	localparam int DPC_BIT_PED = 6;
	localparam int DPC_BIT_RAWHDR = 5;
	localparam int DPC_BIT_BYPASS = 4;
	localparam int DPC_BIT_TRAP = 6;
	localparam int DPC_POS_PEAK = 2;
	localparam logic [7:0] DPC_DUMMY_HDR = 8'h40;
	localparam int DPC_DELAY_TAPS = 8;

	typedef enum logic [1:0] {
		DPC_KILL_AUTO = 2'b00,
		DPC_KILL_RSVD = 2'b01,
		DPC_KILL_FORCE = 2'b10,
		DPC_KILL_OFF = 2'b11
	} dpc_kill_t;

	typedef enum logic [1:0] {
		DPC_OUT_YCBCR = 2'b00,
		DPC_OUT_LUMA2X = 2'b01
	} dpc_omode_t;

	typedef struct packed {
		logic ntsc443_autoswitch_mask;
		logic paln_autoswitch_mask;
		logic palm_autoswitch_mask;
		logic secam_autoswitch_mask;
	} dpc_mask_t;

	typedef struct packed {
		logic main_rise;
		logic sec_rise;
		logic sec_oe;
	} dpc_clkctl_t;

	typedef struct packed {
		logic [7:0] brightness;
		logic [7:0] saturation;
		logic signed [7:0] hue;
		logic [7:0] contrast;
	} dpc_picture_t;
endpackage

// ### testbench/dpc_host_model.sv
`timescale 1ns/100ps
module dpc_host_model (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(negedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [8:0] r);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		r = {reg_hit, reg_rdata};
	endtask
endmodule

// ### testbench/dpc_picture_regs_asserts.sv
`timescale 1ns/100ps
module dpc_picture_regs_asserts import dpc_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit,
	// Autoswitch
	input wire logic [3:0] std_detect_req,
	input wire logic std_detect_valid,
	input wire dpc_pkg::dpc_mask_t autoswitch_mask,
	input wire logic std_accept,
	// Controls
	input wire logic sec_clk_oe,
	input wire logic trap_filter_sel,
	input wire logic [1:0] peaking_gain,
	input wire dpc_pkg::dpc_picture_t picture
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic vreq = std_detect_valid;
	AST_N443: assert property (vreq && std_detect_req == 4'h8 |->
		std_accept == !autoswitch_mask.ntsc443_autoswitch_mask) else $error("ntsc443 accept");
	AST_PALN: assert property (vreq && std_detect_req == 4'h4 |->
		std_accept == !autoswitch_mask.paln_autoswitch_mask) else $error("paln accept");
	AST_PALM: assert property (vreq && std_detect_req == 4'h2 |->
		std_accept == !autoswitch_mask.palm_autoswitch_mask) else $error("palm accept");
	AST_SECAM: assert property (vreq && std_detect_req == 4'h1 |->
		std_accept == !autoswitch_mask.secam_autoswitch_mask) else $error("secam accept");
	AST_SCLK_OE: assert property (reg_wr && reg_addr == 8'h05 |=>
		sec_clk_oe == $past(reg_wdata[3])) else $error("sclk enable");
	AST_PEAK: assert property (reg_wr && reg_addr == 8'h08 |=>
		{trap_filter_sel, peaking_gain} == {$past(reg_wdata[6]), $past(reg_wdata[3:2])})
		else $error("filter or peaking");
	AST_BRIGHT: assert property (reg_wr && reg_addr == 8'h09 |=>
		picture.brightness == $past(reg_wdata)) else $error("brightness");
	AST_HUE: assert property (reg_wr && reg_addr == 8'h0B |=>
		picture.hue == $past(reg_wdata)) else $error("hue");
	AST_READ: assert property (reg_rd && !reg_wr && reg_addr == 8'h0C |=>
		reg_hit && reg_rdata == $past(picture.contrast)) else $error("readback");
	AST_UNMAP: assert property (reg_rd && reg_addr == 8'h00 |=>
		!reg_hit && reg_rdata == 8'h00) else $error("unmapped read");
	AST_KEEP: assert property (!reg_wr |=> $stable(picture)) else $error("drift");
	cover property (reg_wr && reg_addr == 8'h09);
	cover property (vreq && std_accept);
	cover property (reg_rd ##1 reg_hit);
endmodule

// ### testbench/dpc_picture_regs_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module dpc_picture_regs_test;
	import dpc_pkg::*;
	logic sys_clk, sys_rst, reg_wr, reg_rd, reg_hit, std_detect_valid, std_is_secam;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cnt, main_data, sec_data;
	logic [3:0] std_detect_req;
	logic [4:0] burst_level;
	logic vertical_blanking_interval, vertical_active_interval, std_accept, sec_clk_oe, sec_clk_o;
	logic color_killed, pedestal_absent, trap_filter_sel, hue_enable;
	logic [1:0] out_mode, peaking_gain;
	logic [8:0] r;
	dpc_mask_t autoswitch_mask;
	dpc_picture_t picture;
	int fail_count = 0, n_checks = 0, cyc = 0;
	logic [7:0] ra[9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
	logic [7:0] re[9] = '{8'hDC, 8'h08, 8'h10, 8'h60, 8'h00, 8'h80, 8'h80, 8'h00, 8'h80};
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cnt <= sys_rst ? 8'h00 : cnt + 8'h01;
	always @(posedge sys_clk) if (++cyc == 3000) begin
		fail_count++;
		give_verdict();
	end
	dpc_host_model h (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit);
	dpc_picture_regs dut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_hit, .std_detect_req, .std_detect_valid, .std_is_secam,
		.autoswitch_mask, .std_accept, .main_clk(cnt[1]), .sec_clk(cnt[2]), .sec_clk_o,
		.sec_clk_oe, .vertical_blanking_interval, .vertical_active_interval, .luma_in(cnt),
		.luma2x_in(~cnt), .chroma_in(cnt ^ 8'h5A), .burst_level, .raw_header_slot(cnt[4]),
		.main_data, .sec_data, .out_mode, .color_killed, .pedestal_absent,
		.trap_filter_sel, .peaking_gain, .picture, .hue_enable);
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic kill(input logic [7:0] v, input logic [4:0] b, input logic e);
		h.wr(8'h06, v);
		@(posedge sys_clk) burst_level <= b;
		repeat (3) @(negedge sys_clk);
		`CHK(color_killed, e)
	endtask
	initial begin
		{sys_rst, std_detect_req, std_detect_valid, std_is_secam} = {1'b1, 6'h00};
		{burst_level, vertical_blanking_interval, vertical_active_interval} = 7'h02;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		`CHK(autoswitch_mask, 4'b1110)
		foreach (ra[i]) begin
			h.rd(ra[i], r);
			`CHK(r, {1'b1, re[i]})
		end
		foreach (re[i]) begin
			@(posedge sys_clk) std_detect_valid <= 1'b1;
			std_detect_req <= 4'h1 << (i % 4);
			if (i == 4) h.wr(8'h04, 8'h00);
			@(negedge sys_clk) `CHK(std_accept, i > 3 || i == 0)
		end
		h.wr(8'h04, 8'hFF);
		`CHK(std_accept, 1'b0)
		h.wr(8'h05, 8'h00);
		`CHK(sec_clk_oe, 1'b0)
		h.wr(8'h05, 8'h0B);
		`CHK(sec_clk_oe, 1'b1)
		`CHK(sec_clk_o, cnt[2])
		kill(8'h40, 5'h00, 1'b1);
		kill(8'h60, 5'h1F, 1'b0);
		kill(8'h10, 5'h1F, 1'b1);
		kill(8'h1F, 5'h1E, 1'b0);
		for (int g = 0; g < 4; g++) begin
			h.wr(8'h08, {1'b0, g[0], 2'b00, g[1:0], 2'b00});
			`CHK({trap_filter_sel, peaking_gain}, {g[0], g[1:0]})
		end
		h.wr(8'h07, 8'h10);
		@(negedge sys_clk) `CHK({out_mode, pedestal_absent}, {DPC_OUT_LUMA2X, 1'b0})
		@(posedge sys_clk);
		vertical_blanking_interval <= 1'b0;
		vertical_active_interval <= 1'b1;
		repeat (2) @(negedge sys_clk);
		`CHK(out_mode, DPC_OUT_YCBCR)
		h.wr(8'h07, 8'h80);
		@(negedge sys_clk) `CHK(out_mode, DPC_OUT_LUMA2X)
		repeat (10) @(negedge sys_clk);
		`CHK({main_data[1:0], sec_data[2:0]}, 5'b10100)
		h.wr(8'h05, 8'h08);
		repeat (10) @(negedge sys_clk);
		`CHK({main_data[1:0], sec_data[2:0]}, 5'b00000)
		h.wr(8'h07, 8'hA0);
		repeat (10) @(negedge sys_clk);
		while (cnt[4:0] != 5'h1F) @(negedge sys_clk);
		`CHK({main_data, sec_data}, {DPC_DUMMY_HDR, DPC_DUMMY_HDR})
		h.wr(8'h09, 8'hFF);
		h.wr(8'h0A, 8'h00);
		h.wr(8'h0B, 8'h80);
		h.wr(8'h0C, 8'h7F);
		`CHK(picture, 32'hFF00807F)
		`CHK(hue_enable, 1'b1)
		std_is_secam <= 1'b1;
		@(negedge sys_clk) `CHK(hue_enable, 1'b0)
		h.wr(8'h00, 8'h55);
		h.rd(8'h00, r);
		`CHK(r, 9'h000)
		h.rd(8'h0C, r);
		`CHK(r, 9'h17F)
		give_verdict();
	end
endmodule
bind dpc_picture_regs dpc_picture_regs_asserts chk (.sys_clk, .sys_rst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .std_detect_req, .std_detect_valid,
	.autoswitch_mask, .std_accept, .sec_clk_oe, .trap_filter_sel, .peaking_gain, .picture);
